// file: bwucr_map.svh
// Offsets, field positions and reset values of the bridge window registers
// Contract
// - Limit bit 0 mirrors wide prefetch capability
// - Limit field holds A[31:20], low bits ones
// - Full base and limit steer prefetch forwarding
// - Base high reads zero, read-only when narrow
// - Limit high reads zero, ignores writes narrow
// - I/O base high resets ones, zero narrow
// - I/O limit high resets zero, zero narrow
// - Capability head 0x40, lockable read-only value
// - Option ROM base always zero, writes ignored
// - Interrupt routing byte stored, never used
// - Capability bit selects 32 or 64 bit
// - Base field holds A[31:20], 1MB aligned
`ifndef BWUCR_MAP_SVH
`define BWUCR_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define BWUCR_IDX_PF_BASE 8'h24
`define BWUCR_IDX_PF_LIMIT 8'h26
`define BWUCR_IDX_PF_BASE_HIGH 8'h28
`define BWUCR_IDX_PF_LIMIT_HIGH 8'h2C
`define BWUCR_IDX_IO_BASE_HIGH 8'h30
`define BWUCR_IDX_IO_LIMIT_HIGH 8'h32
`define BWUCR_IDX_CAP_HEAD 8'h34
`define BWUCR_IDX_ROM_BASE 8'h38
`define BWUCR_IDX_IRQ_BYTE 8'h3C
`define BWUCR_IDX_IO_CTL 8'h40

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BWUCR_CAP_BIT 0
`define BWUCR_WIN_MSB 15
`define BWUCR_WIN_LSB 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BWUCR_RST_PF_CAP 1'h1
`define BWUCR_RST_PF_BASE 12'hFFF
`define BWUCR_RST_PF_LIMIT 12'h000
`define BWUCR_RST_PF_BASE_HIGH 32'hFFFFFFFF
`define BWUCR_RST_PF_LIMIT_HIGH 32'h00000000
`define BWUCR_RST_IO_BASE_HIGH 16'hFFFF
`define BWUCR_RST_IO_LIMIT_HIGH 16'h0000
`define BWUCR_RST_IO_CAP 1'h1
`define BWUCR_RST_CAP_HEAD 8'h40
`define BWUCR_RST_IRQ_BYTE 8'h00

`endif

// file: bwucr_pkg.sv
// Types and shared helper functions of the bridge window registers
`default_nettype none
package bwucr_pkg;

  // Bus answer state
  typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bwucr_bus_t;

  // Whole state of the register bank
  typedef struct packed {
    bwucr_bus_t bus;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic pf_cap;
    logic [11:0] pf_base;
    logic [11:0] pf_lim;
    logic [31:0] pf_base_hi;
    logic [31:0] pf_lim_hi;
    logic io_cap;
    logic [15:0] io_base_hi;
    logic [15:0] io_lim_hi;
    logic [7:0] cap_head;
    logic [7:0] irq_byte;
  } bwucr_state_t;

  // Two stage synchroniser state
  typedef struct packed {
    logic meta;
    logic level;
  } bwucr_sync_t;

  // Window compare result state
  typedef struct packed {
    logic hit;
    logic valid;
  } bwucr_win_t;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] bwucr_merge(input logic [31:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Full 64-bit window address from high word, A[31:20] and fill
  function automatic logic [63:0] bwucr_full_addr(input logic [31:0] hi,
                                                  input logic [11:0] field,
                                                  input logic fill);
    return {hi, field, {20{fill}}};
  endfunction

endpackage
`default_nettype wire

// file: bwucr_sync.sv
// Two flip-flop synchroniser for a level from a pin
`timescale 1ns/10ps
`default_nettype none
module bwucr_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);
  import bwucr_pkg::*;

  bwucr_sync_t r;
  bwucr_sync_t next_r;

  // Shift the pin through two stages; only the second is read
  always_comb begin
    next_r.meta = async_i;
    next_r.level = r.meta;
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level_o = r.level;
endmodule
`default_nettype wire

// file: bwucr_win.sv
// Registered prefetch window hit decode
`timescale 1ns/10ps
`default_nettype none
module bwucr_win (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [63:0] base_i,
  input wire logic [63:0] limit_i,
  input wire logic [63:0] addr_i,
  input wire logic valid_i,
  output logic hit_o,
  output logic valid_o
);
  import bwucr_pkg::*;

  bwucr_win_t r;
  bwucr_win_t next_r;

  // Inclusive compare; base above limit never hits
  always_comb begin
    next_r.valid = valid_i;
    next_r.hit = valid_i && (addr_i >= base_i) && (addr_i <= limit_i);
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign hit_o = r.hit;
  assign valid_o = r.valid;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Below-base address gives no hit
  below_base_a: assert property (valid_i && addr_i < base_i |=> !hit_o)
    else $error("hit below window base");
  // In-range address gives a hit next cycle
  in_range_a: assert property (valid_i && addr_i >= base_i &&
    addr_i <= limit_i |=> hit_o && valid_o)
    else $error("missed hit inside window");
endmodule
`default_nettype wire

// file: bwucr_regs.sv
// Bridge window upper configuration registers behind an APB slave
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "bwucr_map.svh"
module bwucr_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic CFG_LOCK_I,
  input wire logic [63:0] PF_ADDR_I,
  input wire logic PF_ADDR_VALID_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  output logic PF_WIDE_O,
  output logic IO_WIDE_O,
  output logic PF_HIT_O,
  output logic PF_HIT_VALID_O
);
  import bwucr_pkg::*;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  // The decode reads PADDR_I[9:2] and the map reaches byte address 0x100, so ten address bits at least
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must be at least 10");
  end

  // ------------------------------------------------------------
  // State and reset value
  // ------------------------------------------------------------
  localparam bwucr_state_t RESET_STATE = '{
    bus: BUS_IDLE,
    ready: 1'b0,
    slverr: 1'b0,
    rdata: 32'h00000000,
    pf_cap: `BWUCR_RST_PF_CAP,
    pf_base: `BWUCR_RST_PF_BASE,
    pf_lim: `BWUCR_RST_PF_LIMIT,
    pf_base_hi: `BWUCR_RST_PF_BASE_HIGH,
    pf_lim_hi: `BWUCR_RST_PF_LIMIT_HIGH,
    io_cap: `BWUCR_RST_IO_CAP,
    io_base_hi: `BWUCR_RST_IO_BASE_HIGH,
    io_lim_hi: `BWUCR_RST_IO_LIMIT_HIGH,
    cap_head: `BWUCR_RST_CAP_HEAD,
    irq_byte: `BWUCR_RST_IRQ_BYTE
  };

  bwucr_state_t r; // Registered state
  bwucr_state_t next_r; // Next state
  logic lock; // Synchronised lock strap
  logic [7:0] idx; // Register index from the byte address
  logic addr_ok; // Aligned and inside the decoded page
  logic [31:0] pf_base_hi_eff; // High base as the window sees it
  logic [31:0] pf_lim_hi_eff; // High limit as the window sees it
  logic [15:0] io_base_hi_eff; // I/O high base as read back
  logic [15:0] io_lim_hi_eff; // I/O high limit as read back
  logic [63:0] pf_base_full; // Full 64-bit window base
  logic [63:0] pf_lim_full; // Full 64-bit window limit

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Index is the word number; byte lanes 1:0 must be zero
  assign idx = PADDR_I[9:2];
  assign addr_ok = (PADDR_I[1:0] == 2'h0) && ((PADDR_I >> 10) == '0);

  // ------------------------------------------------------------
  // Narrow-mode gating of the high words
  // ------------------------------------------------------------
  // Stored high words are kept but read and used as zero when narrow
  assign pf_base_hi_eff = r.pf_cap ? r.pf_base_hi : 32'h00000000;
  assign pf_lim_hi_eff = r.pf_cap ? r.pf_lim_hi : 32'h00000000;
  assign io_base_hi_eff = r.io_cap ? r.io_base_hi : 16'h0000;
  assign io_lim_hi_eff = r.io_cap ? r.io_lim_hi : 16'h0000;

  // ------------------------------------------------------------
  // Full window addresses
  // ------------------------------------------------------------
  // Base low bits are zero for 1MB alignment
  assign pf_base_full = bwucr_full_addr(pf_base_hi_eff, r.pf_base, 1'b0);
  // Limit low twenty bits are taken as all ones
  assign pf_lim_full = bwucr_full_addr(pf_lim_hi_eff, r.pf_lim, 1'b1);

  // ------------------------------------------------------------
  // Lock strap synchroniser
  // ------------------------------------------------------------
  // Lock freezes the capability bit and the capability head
  bwucr_sync u_lock_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(CFG_LOCK_I),
    .level_o(lock)
  );

  // ------------------------------------------------------------
  // Prefetch window decode
  // ------------------------------------------------------------
  // Forwarding decision from the combined window
  bwucr_win u_win (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .base_i(pf_base_full),
    .limit_i(pf_lim_full),
    .addr_i(PF_ADDR_I),
    .valid_i(PF_ADDR_VALID_I),
    .hit_o(PF_HIT_O),
    .valid_o(PF_HIT_VALID_O)
  );

  // ------------------------------------------------------------
  // Next state: read mux, bus answer and register writes
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] rd; // Read value of the addressed register
    logic mapped; // Index names a register
    logic [31:0] m; // Merged write word
    rd = 32'h00000000;
    mapped = 1'b1;
    m = 32'h00000000;
    next_r = r;
    // Read mux; reserved bits read as zero
    unique case (idx)
      `BWUCR_IDX_PF_BASE: begin
        rd = {16'h0000, r.pf_base, 3'h0, r.pf_cap};
      end
      `BWUCR_IDX_PF_LIMIT: begin
        // Bit 0 mirrors the capability bit
        rd = {16'h0000, r.pf_lim, 3'h0, r.pf_cap};
      end
      `BWUCR_IDX_PF_BASE_HIGH: begin
        rd = pf_base_hi_eff;
      end
      `BWUCR_IDX_PF_LIMIT_HIGH: begin
        rd = pf_lim_hi_eff;
      end
      `BWUCR_IDX_IO_BASE_HIGH: begin
        rd = {16'h0000, io_base_hi_eff};
      end
      `BWUCR_IDX_IO_LIMIT_HIGH: begin
        rd = {16'h0000, io_lim_hi_eff};
      end
      `BWUCR_IDX_CAP_HEAD: begin
        rd = {24'h000000, r.cap_head};
      end
      `BWUCR_IDX_ROM_BASE: begin
        rd = 32'h00000000; // No option ROM
      end
      `BWUCR_IDX_IRQ_BYTE: begin
        rd = {24'h000000, r.irq_byte};
      end
      `BWUCR_IDX_IO_CTL: begin
        rd = {31'h00000000, r.io_cap};
      end
      default: begin
        mapped = 1'b0; // Unmapped word answers with an error
      end
    endcase
    // Bus answer sequence
    unique case (r.bus)
      BUS_IDLE: begin
        // Setup phase seen: answer in the first access cycle
        if (PSEL_I && !PENABLE_I) begin
          next_r.bus = BUS_ANSWER;
          next_r.ready = 1'b1;
          next_r.slverr = !(addr_ok && mapped);
          next_r.rdata = (!PWRITE_I && addr_ok) ? rd : 32'h00000000;
        end
      end
      BUS_ANSWER: begin
        // Access completes at this edge; drop the answer
        next_r.bus = BUS_IDLE;
        next_r.ready = 1'b0;
        next_r.slverr = 1'b0;
        next_r.rdata = 32'h00000000;
        if (PSEL_I && PENABLE_I && PWRITE_I && addr_ok) begin
          unique case (idx)
            `BWUCR_IDX_PF_BASE: begin
              m = bwucr_merge({16'h0000, r.pf_base, 3'h0, r.pf_cap},
                              PWDATA_I, PSTRB_I);
              next_r.pf_base = m[`BWUCR_WIN_MSB:`BWUCR_WIN_LSB];
              // Capability bit is writable until locked
              if (!lock) begin
                next_r.pf_cap = m[`BWUCR_CAP_BIT];
              end
            end
            `BWUCR_IDX_PF_LIMIT: begin
              // Only A[31:20] is writable; bit 0 stays a mirror
              m = bwucr_merge({16'h0000, r.pf_lim, 4'h0}, PWDATA_I, PSTRB_I);
              next_r.pf_lim = m[`BWUCR_WIN_MSB:`BWUCR_WIN_LSB];
            end
            `BWUCR_IDX_PF_BASE_HIGH: begin
              // Read-only while narrow
              if (r.pf_cap) begin
                next_r.pf_base_hi = bwucr_merge(r.pf_base_hi, PWDATA_I,
                                                PSTRB_I);
              end
            end
            `BWUCR_IDX_PF_LIMIT_HIGH: begin
              // Writes ignored while narrow
              if (r.pf_cap) begin
                next_r.pf_lim_hi = bwucr_merge(r.pf_lim_hi, PWDATA_I,
                                               PSTRB_I);
              end
            end
            `BWUCR_IDX_IO_BASE_HIGH: begin
              // Read-only while I/O is narrow
              if (r.io_cap) begin
                m = bwucr_merge({16'h0000, r.io_base_hi}, PWDATA_I, PSTRB_I);
                next_r.io_base_hi = m[15:0];
              end
            end
            `BWUCR_IDX_IO_LIMIT_HIGH: begin
              // Read-only while I/O is narrow
              if (r.io_cap) begin
                m = bwucr_merge({16'h0000, r.io_lim_hi}, PWDATA_I, PSTRB_I);
                next_r.io_lim_hi = m[15:0];
              end
            end
            `BWUCR_IDX_CAP_HEAD: begin
              // Loadable until the lock strap is seen
              if (!lock) begin
                m = bwucr_merge({24'h000000, r.cap_head}, PWDATA_I, PSTRB_I);
                next_r.cap_head = m[7:0];
              end
            end
            `BWUCR_IDX_IRQ_BYTE: begin
              // Stored only; read back over the bus, used by no other logic
              m = bwucr_merge({24'h000000, r.irq_byte}, PWDATA_I, PSTRB_I);
              next_r.irq_byte = m[7:0];
            end
            `BWUCR_IDX_IO_CTL: begin
              m = bwucr_merge({31'h00000000, r.io_cap}, PWDATA_I, PSTRB_I);
              next_r.io_cap = m[0];
            end
            default: begin
              // Option ROM and unmapped words drop writes
              next_r.bus = BUS_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Synchronous active-low reset to the documented values
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs, each straight from a state flop
  // ------------------------------------------------------------
  assign PREADY_O = r.ready;
  assign PRDATA_O = r.rdata;
  assign PSLVERR_O = r.slverr;
  assign PF_WIDE_O = r.pf_cap;
  assign IO_WIDE_O = r.io_cap;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Completed read or write of a given word
  sequence rd_done_s(logic [7:0] w);
    PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && addr_ok && idx == w;
  endsequence
  sequence wr_done_s(logic [7:0] w);
    PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && addr_ok && idx == w;
  endsequence
  sequence setup_s;
    PSEL_I && !PENABLE_I && !PREADY_O;
  endsequence

  // Setup is answered in the next cycle for exactly one cycle
  bus_answer_a: assert property (setup_s |=> PREADY_O ##1 !PREADY_O)
    else $error("access phase not answered in one cycle");
  // Limit bit 0 reads the capability bit
  limit_mirror_a: assert property (
    rd_done_s(`BWUCR_IDX_PF_LIMIT) |-> PRDATA_O[0] == r.pf_cap)
    else $error("limit bit 0 differs from capability");
  // Base high reads zero while narrow
  base_high_zero_a: assert property (
    rd_done_s(`BWUCR_IDX_PF_BASE_HIGH) ##0 !r.pf_cap |-> PRDATA_O == '0)
    else $error("base high not zero while narrow");
  // Limit high ignores writes while narrow
  limit_high_hold_a: assert property (
    wr_done_s(`BWUCR_IDX_PF_LIMIT_HIGH) ##0 !r.pf_cap
      |=> r.pf_lim_hi == $past(r.pf_lim_hi))
    else $error("limit high written while narrow");
  // I/O base high reads zero while narrow
  io_base_zero_a: assert property (
    rd_done_s(`BWUCR_IDX_IO_BASE_HIGH) ##0 !r.io_cap |-> PRDATA_O == '0)
    else $error("io base high not zero while narrow");
  // Full-lane I/O limit high write lands while wide
  io_limit_write_a: assert property (
    wr_done_s(`BWUCR_IDX_IO_LIMIT_HIGH) ##0 (r.io_cap && PSTRB_I == 4'hF)
      |=> r.io_lim_hi == $past(PWDATA_I[15:0]))
    else $error("io limit high write lost");
  // Locked capability head holds its value
  cap_head_lock_a: assert property (
    wr_done_s(`BWUCR_IDX_CAP_HEAD) ##0 lock |=> $stable(r.cap_head))
    else $error("capability head changed while locked");
  // Option ROM base always reads zero
  rom_zero_a: assert property (
    rd_done_s(`BWUCR_IDX_ROM_BASE) |-> PRDATA_O == '0 && !PSLVERR_O)
    else $error("option rom base not zero");
  // Interrupt byte keeps a full-lane write
  irq_store_a: assert property (
    wr_done_s(`BWUCR_IDX_IRQ_BYTE) ##0 (PSTRB_I == 4'hF)
      |=> r.irq_byte == $past(PWDATA_I[7:0]))
    else $error("interrupt byte write lost");
  // I/O limit high reads zero while narrow
  io_limit_zero_a: assert property (
    rd_done_s(`BWUCR_IDX_IO_LIMIT_HIGH) ##0 !r.io_cap |-> PRDATA_O == '0)
    else $error("io limit high not zero while narrow");
  // Locked capability bit holds its value
  cap_bit_lock_a: assert property (
    wr_done_s(`BWUCR_IDX_PF_BASE) ##0 lock |=> $stable(r.pf_cap))
    else $error("capability bit changed while locked");
  // Full-lane limit write lands in the A[31:20] field
  limit_field_a: assert property (
    wr_done_s(`BWUCR_IDX_PF_LIMIT) ##0 (PSTRB_I == 4'hF)
      |=> r.pf_lim == $past(PWDATA_I[`BWUCR_WIN_MSB:`BWUCR_WIN_LSB]))
    else $error("limit field write lost");
  // Full-lane base write lands in the A[31:20] field
  base_field_a: assert property (
    wr_done_s(`BWUCR_IDX_PF_BASE) ##0 (PSTRB_I == 4'hF)
      |=> r.pf_base == $past(PWDATA_I[`BWUCR_WIN_MSB:`BWUCR_WIN_LSB]))
    else $error("base field write lost");
endmodule
`default_nettype wire

// file: bridge_window_upper_config_regs_bench.sv
// Self-checking bench for the bridge window upper configuration registers
`timescale 1ns/10ps
`default_nettype none
module bridge_window_upper_config_regs_bench;
  import bwucr_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk, rst_n, psel, penable, pwrite, cfg_lock, pf_valid; // Drives
  logic [11:0] paddr; // Byte address
  logic [31:0] pwdata; // Write word
  logic [3:0] pstrb; // Lane strobes
  logic [63:0] pf_addr; // Address to decode
  logic pready, pslverr, pf_wide, io_wide, pf_hit, pf_hit_valid; // Outputs
  logic [31:0] prdata; // Read word
  int n_fail = 0; // Mismatches
  int compares = 0; // Comparisons
  int cycles = 0; // Hang guard
  logic [31:0] bh, lh, rd_v, d; // Window high words, read value
  logic [11:0] bf, lf; // Window fields
  logic err; // Error answer
  logic [63:0] a; // Window probe
  logic [31:0] last [6]; // Last words written per RW register
  // Reset values table
  logic [11:0] rst_a [10] = '{12'h090, 12'h098, 12'h0A0, 12'h0B0, 12'h0C0,
    12'h0C8, 12'h0D0, 12'h0E0, 12'h0F0, 12'h100};
  logic [31:0] rst_e [10] = '{32'h0000FFF1, 32'h00000001, 32'hFFFFFFFF,
    32'h00000000, 32'h0000FFFF, 32'h00000000, 32'h00000040, 32'h00000000,
    32'h00000000, 32'h00000001};
  // Writable registers and their widths
  logic [11:0] rw_a [6] = '{12'h0A0, 12'h0B0, 12'h0C0, 12'h0C8, 12'h0D0,
    12'h0F0};
  logic [31:0] rw_m [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF,
    32'h0000FFFF, 32'h000000FF, 32'h000000FF};

  bwucr_regs dut (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .CFG_LOCK_I(cfg_lock), .PF_ADDR_I(pf_addr), .PF_ADDR_VALID_I(pf_valid),
    .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
    .PF_WIDE_O(pf_wide), .IO_WIDE_O(io_wide), .PF_HIT_O(pf_hit),
    .PF_HIT_VALID_O(pf_hit_valid)
  );

  // ------------------------------------------------------------
  // Clock, hang guard and verdict
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts the run short if a wait never ends
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Compare tasks, bus cycles and expectation
  // ------------------------------------------------------------
  task automatic chk_data(input logic [31:0] got, input logic [31:0] ex,
                          input string msg);
    compares++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, ex);
    end
  endtask

  task automatic chk_bit(input logic got, input logic ex, input string msg);
    compares++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %0t %s got %b expected %b", $time, msg, got, ex);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] dt, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    // Sample pready, data and error at the rising edge itself
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_bit(n == 0, 1'b1, "answer in first access cycle");
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt, 4'hF);
    chk_bit(err, 1'b0, "write error flag");
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] ex);
    apb(1'b0, ad, 32'h00000000, 4'h0);
    chk_data(rd_v, ex, "read data");
    chk_bit(err, 1'b0, "read error flag");
  endtask

  // Expected hit from the bench's copy of the window registers
  function automatic logic exp_hit(input logic [63:0] ad, input logic wide);
    logic [63:0] b, l;
    b = {wide ? bh : 32'h00000000, bf, 20'h00000};
    l = {wide ? lh : 32'h00000000, lf, 20'hFFFFF};
    return (ad >= b) && (ad <= l);
  endfunction

  // Presents one address and checks the answer a cycle later
  task automatic win(input logic [63:0] ad, input logic wide);
    @(posedge clk);
    pf_addr <= ad;
    pf_valid <= 1'b1;
    @(posedge clk);
    pf_valid <= 1'b0;
    @(negedge clk);
    chk_bit(pf_hit_valid, 1'b1, "hit qualifier");
    chk_bit(pf_hit, exp_hit(ad, wide), "window hit");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, cfg_lock, pf_valid} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    pf_addr = 64'h0;
    void'($urandom(51));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_bit(pf_wide, 1'b1, "wide after reset");
    for (int i = 0; i < 10; i++) begin
      rd(rst_a[i], rst_e[i]);
    end
    $display("reset values done");
    // Ones, zeros, then random words into each of the six registers in the rw_a table
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 3; k++) begin
        d = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h00000000 : $urandom;
        wr(rw_a[i], d);
        rd(rw_a[i], d & rw_m[i]);
        last[i] = d & rw_m[i];
      end
    end
    apb(1'b1, 12'h0A0, 32'hAABBCCDD, 4'h5);
    last[0] = {last[0][31:24], 8'hBB, last[0][15:8], 8'hDD};
    rd(12'h0A0, last[0]);
    $display("read write done");
    wr(12'h098, 32'h0000ABC0);
    rd(12'h098, 32'h0000ABC1);
    wr(12'h0E0, 32'hFFFFFFFF);
    rd(12'h0E0, 32'h00000000);
    apb(1'b0, 12'h0F4, 32'h00000000, 4'h0);
    chk_bit(err, 1'b1, "unmapped read");
    apb(1'b1, 12'h0A1, 32'h00000000, 4'hF);
    chk_bit(err, 1'b1, "misaligned write");
    apb(1'b1, 12'h4A0, 32'h00000000, 4'hF);
    chk_bit(err, 1'b1, "high address bits");
    rd(12'h0A0, last[0]);
    $display("refusals done");
    // Narrow mode hides and protects the high words
    wr(12'h090, 32'h00000000);
    repeat (2) @(negedge clk);
    chk_bit(pf_wide, 1'b0, "narrow flag");
    rd(12'h098, 32'h0000ABC0);
    rd(12'h0A0, 32'h00000000);
    wr(12'h0B0, 32'h12345678);
    rd(12'h0B0, 32'h00000000);
    wr(12'h0A0, 32'h5A5A5A5A);
    wr(12'h090, 32'h00000001);
    rd(12'h0A0, last[0]);
    rd(12'h0B0, last[1]);
    wr(12'h100, 32'h00000000);
    repeat (2) @(negedge clk);
    chk_bit(io_wide, 1'b0, "io narrow flag");
    wr(12'h0C0, 32'h00001234);
    rd(12'h0C0, 32'h00000000);
    rd(12'h0C8, 32'h00000000);
    wr(12'h100, 32'h00000001);
    rd(12'h0C0, last[2]);
    $display("narrow mode done");
    // Lock strap freezes the capability bit and list head
    cfg_lock <= 1'b1;
    repeat (5) @(posedge clk);
    wr(12'h0D0, 32'h00000077);
    rd(12'h0D0, last[4]);
    wr(12'h090, 32'h00000000);
    rd(12'h090, 32'h00000001);
    cfg_lock <= 1'b0;
    repeat (5) @(posedge clk);
    wr(12'h0D0, 32'h00000077);
    rd(12'h0D0, 32'h00000077);
    $display("lock done");
    // Window decode at the edges, at random, narrow and empty
    {bf, lf, bh, lh} = {12'h400, 12'hBFF, 32'h00000001, 32'h00000001};
    wr(12'h090, {16'h0000, bf, 4'h1});
    wr(12'h098, {16'h0000, lf, 4'h0});
    wr(12'h0A0, bh);
    wr(12'h0B0, lh);
    win({bh, bf, 20'h00000}, 1'b1);
    win({bh, bf, 20'h00000} - 64'h1, 1'b1);
    win({lh, lf, 20'hFFFFF}, 1'b1);
    win({lh, lf, 20'hFFFFF} + 64'h1, 1'b1);
    for (int i = 0; i < 24; i++) begin
      a = {(i % 4 == 0) ? 32'($urandom) : bh, 32'($urandom)};
      win(a, 1'b1);
    end
    wr(12'h090, {16'h0000, bf, 4'h0});
    win({32'h00000000, bf, 20'h00000}, 1'b0);
    win({bh, bf, 20'h00000}, 1'b0);
    bf = 12'hFFF;
    wr(12'h090, {16'h0000, bf, 4'h1});
    for (int i = 0; i < 8; i++) begin
      win({bh, 32'($urandom)}, 1'b1);
    end
    $display("window done");
    give_verdict();
  end
endmodule
`default_nettype wire
